// ===== src/sirt_status.v
/*
 status field transition logic of a command interface, out of idle.
 assumes a classic wishbone master with 32-bit data, single cycles.
*/
// Chosen here: register access over Wishbone and the address map.
// Contract
// - after command completion the device settles through intermediate states before data-available rises.
// - status flags are meaningful only while status-valid reads one.
// - an idle ending may be replaced by a silent move straight to ready.
// - once idle time reaches the timeout the device stays idle until the host commands ready.
// - below the timeout the device may enter ready itself, with command-ready 1 and data-available 0.
// - expect on idle-to-ready takes one fixed chosen value, held in ready.
// - in idle a host write of one to command-ready moves to ready.
// - in idle writes to the command fifo are dropped and all flags stay zero.
// - in idle a fifo read returns ff and leaves the state alone.
// - in idle a write of one to execute-go has no effect.
`timescale 1ns/1ps
`include "sirt_map.vh"
module sirt_status
#(
    parameter IDLE_CYCLES = (`SIRT_IDLE_TIMEOUT_US * 1000) / `SIRT_CLK_NS
)
(
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg irq_o
);
    // ==================================================
    // states
    localparam ST_IDLE = 2'd0;
    localparam ST_READY = 2'd1;
    localparam ST_SETTLE = 2'd2;
    localparam ST_AVAIL = 2'd3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] ctrl_reg;
    reg [2:0] int_stat_reg;
    reg [2:0] int_mask_reg;
    reg expect_reg;
    reg valid_reg;
    reg [1:0] settle_reg;
    wire expired;
    wire req;
    wire wr;
    wire rd;
    wire [31:0] status_word;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i && sel_i[0];
    assign rd = req && !we_i;

    // ==================================================
    // register decode and state events
    wire wr_ctrl;
    wire wr_mask;
    wire rd_int_stat;
    wire enter_ready;
    wire enter_avail;
    wire valid_back;

    assign wr_ctrl = wr && (adr_i == `SIRT_CTRL_OFS);
    assign wr_mask = wr && (adr_i == `SIRT_INT_MASK_OFS);
    assign rd_int_stat = rd && (adr_i == `SIRT_INT_STAT_OFS);
    assign enter_ready = (state_next == ST_READY) && (state_reg != ST_READY);
    assign enter_avail = (state_next == ST_AVAIL) && (state_reg != ST_AVAIL);
    // valid comes back one cycle after a change, once the state holds
    assign valid_back = !valid_reg && (state_next == state_reg);

    sirt_idle_timer #(.CYCLES(IDLE_CYCLES), .W(32)) u_timer
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .idle_i(state_reg == ST_IDLE),
        .expired_o(expired)
    );

    // ==================================================
    // status word
    assign status_word = {24'h000000, valid_reg, state_reg == ST_READY, 1'b0,
        state_reg == ST_AVAIL, expect_reg && state_reg == ST_READY, 3'h0};

    // ==================================================
    // next state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (wr && adr_i == `SIRT_STATUS_OFS && dat_i[`SIRT_ST_CMD_READY])
                    state_next = ST_READY;
                else if (ctrl_reg[`SIRT_CT_AUTO_READY] && !expired)
                    state_next = ST_READY;
                // expired: hold idle, go and fifo writes are ignored
            end
            ST_READY:
            begin
                if (wr && adr_i == `SIRT_CTRL_OFS && dat_i[`SIRT_CT_CMD_DONE])
                    state_next = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                if (settle_reg == 2'd0)
                    state_next = ST_AVAIL;
            end
            ST_AVAIL:
            begin
                if (wr && adr_i == `SIRT_STATUS_OFS && dat_i[`SIRT_ST_CMD_READY])
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // ==================================================
    // state, status-valid and expect
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            valid_reg <= 1'b1;
            expect_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // status-valid drops across any change of state
            valid_reg <= (state_next == state_reg);
            if (state_reg == ST_IDLE && state_next == ST_READY)
                expect_reg <= ctrl_reg[`SIRT_CT_EXPECT_CHOICE];
        end
    end

    // ==================================================
    // settle counter between command done and data-available
    always @(posedge clk_i)
    begin
        if (rst_i)
            settle_reg <= 2'd0;
        else if (state_next == ST_SETTLE && state_reg != ST_SETTLE)
            settle_reg <= 2'd`SIRT_SETTLE_CYC;
        else if (settle_reg != 2'd0)
            settle_reg <= settle_reg - 2'd1;
    end

    // ==================================================
    // control and mask registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= `SIRT_CTRL_RST;
            int_mask_reg <= 3'h0;
        end
        else
        begin
            // command-done is a strobe, never stored
            if (wr_ctrl)
                ctrl_reg <= {1'b0, dat_i[1:0]};
            else
                ctrl_reg[`SIRT_CT_CMD_DONE] <= 1'b0;
            if (wr_mask)
                int_mask_reg <= dat_i[2:0];
        end
    end

    // ==================================================
    // sticky interrupt status and level output
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_stat_reg <= 3'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            // set wins over read-clear so an event in the read cycle is not lost
            int_stat_reg <= (rd_int_stat ? 3'h0 : int_stat_reg) | {valid_back, enter_avail, enter_ready};
            irq_o <= |(int_stat_reg & int_mask_reg);
        end
    end

    // ==================================================
    // bus answer
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= req;
            dat_o <= 32'h00000000;
            if (rd)
            begin
                case (adr_i)
                    `SIRT_STATUS_OFS: dat_o <= status_word;
                    `SIRT_FIFO_OFS: dat_o <= {24'h000000, `SIRT_FILLER};
                    `SIRT_CTRL_OFS: dat_o <= {29'h00000000, ctrl_reg};
                    `SIRT_INT_STAT_OFS: dat_o <= {29'h00000000, int_stat_reg};
                    `SIRT_INT_MASK_OFS: dat_o <= {29'h00000000, int_mask_reg};
                    default: dat_o <= 32'h00000000;
                endcase
            end
            // fifo writes and execute-go are dropped in every state: no register loads them
        end
    end
endmodule

// ===== src/sirt_map.vh
/*
 holds register offsets, field positions, reset values and timing counts
 of the status transition block; assumes a 32-bit classic wishbone slave.
*/
`ifndef SIRT_MAP_VH
`define SIRT_MAP_VH
// ==================================================
// register byte offsets
`define SIRT_STATUS_OFS 8'h00
`define SIRT_FIFO_OFS 8'h04
`define SIRT_CTRL_OFS 8'h08
`define SIRT_INT_STAT_OFS 8'h0c
`define SIRT_INT_MASK_OFS 8'h10
// ==================================================
// status_register fields
`define SIRT_ST_VALID 7
`define SIRT_ST_CMD_READY 6
`define SIRT_ST_GO 5
`define SIRT_ST_DATA_AVAIL 4
`define SIRT_ST_EXPECT 3
`define SIRT_ST_RESEND 1
// ctrl fields
`define SIRT_CT_AUTO_READY 0
`define SIRT_CT_EXPECT_CHOICE 1
`define SIRT_CT_CMD_DONE 2
// interrupt status fields
`define SIRT_IS_READY 0
`define SIRT_IS_DATA_AVAIL 1
`define SIRT_IS_VALID 2
// ==================================================
// reset values and constants
`define SIRT_CTRL_RST 3'h1
`define SIRT_FILLER 8'hff
// idle timeout in microseconds, clock period in nanoseconds
`define SIRT_IDLE_TIMEOUT_US 750
`define SIRT_CLK_NS 100
`define SIRT_SETTLE_CYC 2
`endif

// ===== src/sirt_idle_timer.v
/*
 idle timer: counts cycles since entering idle and flags expiry.
 assumes idle_i is high exactly while the status machine sits in idle.
*/
`timescale 1ns/1ps
module sirt_idle_timer
#(
    parameter CYCLES = 7500,
    parameter W = 16
)
(
    input wire clk_i,
    input wire rst_i,
    input wire idle_i,
    output reg expired_o
);
    reg [W-1:0] cnt_reg;
    // count saturates so a long idle stays expired until idle is left
    always @(posedge clk_i)
    begin
        if (rst_i || !idle_i)
        begin
            cnt_reg <= {W{1'b0}};
            expired_o <= 1'b0;
        end
        else if (!expired_o)
        begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            expired_o <= (cnt_reg >= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule

// ===== test/sirt_host.sv
/* host model: classic wishbone master for sirt_status
   assumes the slave always answers with ack */
`timescale 1ns/1ps
module sirt_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial
    begin
        cyc_o = 1'h0;
        stb_o = 1'h0;
        we_o = 1'h0;
        adr_o = 8'h00;
        sel_o = 4'hf;
        dat_o = 32'h0;
    end
    // ==========
    // one single cycle; the request is held until ack is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc_o <= 1'h1;
        stb_o <= 1'h1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'h1);
        r = dat_i;
        cyc_o <= 1'h0;
        stb_o <= 1'h0;
    endtask
endmodule

// ===== test/sirt_status_checker.sv
/* port checker of sirt_status
   assumes one clock and a sync reset */
`timescale 1ns/1ps
module sirt_status_checker (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========
    // status reads seen at the answering edge
    wire rs = ack_o & !we_i & adr_i == 8'h00;
    property p_ack; cyc_i & stb_i & !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_cause; $rose(ack_o) |-> $past(cyc_i & stb_i); endproperty
    a_cause: assert property (p_cause) else $error("stray ack");
    property p_fifo; ack_o & !we_i & adr_i == 8'h04 |-> dat_o == 32'hff; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo filler");
    property p_ready; rs & dat_o[7] & dat_o[6] |-> !dat_o[4]; endproperty
    a_ready: assert property (p_ready) else $error("ready flags");
    property p_go; rs |-> !dat_o[5] && !dat_o[1]; endproperty
    a_go: assert property (p_go) else $error("go reads set");
    property p_idle; rs & dat_o[7] & !dat_o[6] & !dat_o[4] |-> !dat_o[3]; endproperty
    a_idle: assert property (p_idle) else $error("idle expect");
    property p_unmap; ack_o & !we_i & adr_i > 8'h10 |-> dat_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind sirt_status sirt_status_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));

// ===== test/status_idle_ready_transitions_test.sv
/* self-checking bench of sirt_status
   assumes sirt_host drives the bus */
`timescale 1ns/1ps
module status_idle_ready_transitions_test;
    logic clk = 0;
    logic rst = 1;
    logic cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd, q;
    int fail_count = 0;
    int checks = 0;
    int n_cyc = 0;
    logic [31:0] seed = 32'h0000a947;
    always #50 clk = ~clk;
    sirt_status #(.IDLE_CYCLES(20)) DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .irq_o(irq));
    sirt_host host (.clk_i(clk), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] st(input logic c, input logic a, input logic e);
        return {24'h0, 1'h1, c, 1'h0, a, e, 3'h0};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'h1, a, d, q);
    endtask
    // polls until status is valid with one of the flags in m set
    task automatic poll(input logic [31:0] m);
        int n = 0;
        do host.xfer(1'h0, 8'h00, rnd(), q); while ((q[7] !== 1'h1 || (q & m) == 0) && ++n < 40);
    endtask
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // sequence
    always @(posedge clk)
    begin
        n_cyc++;
        if (n_cyc == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        poll(32'h40);
        chk(q, st(1, 0, 0));
        wr(8'h08, 32'h4);
        poll(32'h10);
        chk(q, st(0, 1, 0));
        wr(8'h00, 32'h40);
        wr(8'h04, rnd());
        host.xfer(1'h0, 8'h04, rnd(), q);
        chk(q, 32'hff);
        wr(8'h00, 32'h20);
        poll(32'h80);
        chk(q, st(0, 0, 0));
        host.xfer(1'h0, 8'h0c, rnd(), q);
        wr(8'h10, 32'h1);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h40);
        poll(32'h40);
        chk(q, st(1, 0, 1));
        chk({31'h0, irq}, 32'h1);
        host.xfer(1'h0, 8'h0c, rnd(), q);
        chk(q & 32'h1, 32'h1);
        host.xfer(1'h0, 8'h0c, rnd(), q);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h08, 32'h4);
        poll(32'h10);
        wr(8'h00, 32'h40);
        repeat (30) @(posedge clk);
        wr(8'h08, 32'h1);
        repeat (10) @(posedge clk);
        poll(32'h80);
        chk(q, st(0, 0, 0));
        host.xfer(1'h0, 8'h40, rnd(), q);
        chk(q, 32'h0);
        print_verdict();
    end
endmodule
